// ===== pcirq_pkg.sv
// Purpose: shared constants for the pin-change interrupt block
// Assumes: AXI4-Lite slave, 32-bit data, one word per register
// Notes: register offsets are word indices; byte address is index * 4
package pcirq_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = ADDR_W - 2;
  localparam int NUM_GROUPS = 4;
  localparam int GROUP_W = 8;
  localparam int NUM_PINS = NUM_GROUPS * GROUP_W;

  // word indices of the registers
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h068;
  localparam logic [IDX_W-1:0] IDX_CORE = 10'h069;
  localparam logic [IDX_W-1:0] IDX_FLAGS = 10'h06a;
  localparam logic [IDX_W-1:0] IDX_MASK0 = 10'h06b;
  localparam logic [IDX_W-1:0] IDX_MASK1 = 10'h06c;
  localparam logic [IDX_W-1:0] IDX_MASK2 = 10'h06d;
  localparam logic [IDX_W-1:0] IDX_MASK3 = 10'h073;

  // field positions and reset values
  localparam int GLOBAL_EN_BIT = 0;
  localparam logic [NUM_GROUPS-1:0] CTRL_RESET = 4'h0;
  localparam logic [NUM_GROUPS-1:0] FLAGS_RESET = 4'h0;
  localparam logic [GROUP_W-1:0] MASK_RESET = 8'h00;
  localparam logic GLOBAL_EN_RESET = 1'b0;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== pcirq_change_detect.sv
// Purpose: synchronise one group of pins and flag masked changes
// Assumes: pins are asynchronous to aclk
// Notes: hit is a one-cycle pulse, registered
`timescale 1ns/100ps
`default_nettype none
module pcirq_change_detect #(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] pins,
  input wire logic [WIDTH-1:0] mask,
  input wire logic group_en,
  output logic hit
);
  import pcirq_pkg::*;

  logic [WIDTH-1:0] sync1;
  logic [WIDTH-1:0] sync2;
  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] changed;

  // two-flop synchroniser, then one more stage for edge compare
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      prev <= '0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      prev <= sync2; // R12
    end
  end

  // per-pin enable is mask bit and group enable together
  assign changed = (sync2 ^ prev) & mask & {WIDTH{group_en}}; // R09

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit <= 1'b0;
    end else begin
      hit <= |changed; // R12
    end
  end

  mask_ignore_a: // R09
  assert property (@(posedge aclk) disable iff (!aresetn)
    (mask == '0) |=> !hit)
  else $error("change seen on a fully masked group");

  one_hit_a: // R12
  assert property (@(posedge aclk) disable iff (!aresetn)
    hit |-> $past(sync2 != prev))
  else $error("hit without a sampled change");
endmodule
`default_nettype wire

// ===== pcirq_top.sv
// Purpose: pin-change interrupt logic, 32 pins in four groups of eight
// Assumes: vector_taken is a one-cycle pulse from the core, same clock
// Notes: flags use set-over-clear; all outputs are registered
// Function
// R01: group 0 flag sets on a change of any enabled pin 0 to 7.
// R02: set flag with global and group enable requests that group's vector.
// R03: taking a group's vector clears that group's flag.
// R04: writing one to a flag bit clears it; writing zero keeps it.
// R05: group 3 mask enables pins 24 to 31, qualified by group 3 enable.
// R06: group 2 mask enables pins 16 to 23, qualified by group 2 enable.
// R07: group 1 mask enables pins 8 to 15, qualified by group 1 enable.
// R08: group 0 mask enables pins 0 to 7, qualified by group 0 enable.
// R09: a pin with mask bit zero never causes a change event.
// R10: control bits 3:0 are group enables; upper bits read zero; reset zero.
// R11: groups 1 to 3 have flags set and cleared like group 0.
// R12: pins are synchronised; one transition sets the flag once.
// R13: all four masks are read/write and reset to zero.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module pcirq_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pcirq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [pcirq_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [pcirq_pkg::DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pcirq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [pcirq_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [pcirq_pkg::NUM_PINS-1:0] change_pins,
  input wire logic [pcirq_pkg::NUM_GROUPS-1:0] vector_taken,
  output logic [pcirq_pkg::NUM_GROUPS-1:0] vector_request,
  output logic irq
);
  import pcirq_pkg::*;

  // register state
  logic [NUM_GROUPS-1:0] change_group_control;
  logic [NUM_GROUPS-1:0] change_group_flags;
  logic [NUM_GROUPS*GROUP_W-1:0] pin_mask;
  logic global_irq_enable;

  // bus state
  logic aw_full;
  logic w_full;
  logic ar_full;
  logic next_aw_full;
  logic next_w_full;
  logic next_ar_full;
  logic [IDX_W-1:0] aw_idx;
  logic [IDX_W-1:0] ar_idx;
  logic [DATA_W-1:0] wr_data;
  logic wr_lane0;
  logic wr_go;
  logic rd_go;
  logic wr_hit;
  logic rd_hit;
  logic [DATA_W-1:0] rd_word;

  // event paths
  logic [NUM_GROUPS-1:0] group_hit;
  logic [NUM_GROUPS-1:0] flag_clear;
  logic [NUM_GROUPS-1:0] next_flags;
  logic [NUM_GROUPS-1:0] next_request;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // change detectors, one per group of eight pins
  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g++) begin : gen_group
      pcirq_change_detect #(
        .WIDTH(GROUP_W)
      ) u_detect (
        .aclk(aclk),
        .aresetn(aresetn),
        .pins(change_pins[g*GROUP_W +: GROUP_W]),
        .mask(pin_mask[g*GROUP_W +: GROUP_W]), // R05 R06 R07 R08
        .group_en(change_group_control[g]),
        .hit(group_hit[g])
      );
    end
  endgenerate

  // write channel capture: address and data in either order
  assign wr_go = aw_full && w_full && !s_axi_bvalid;
  assign rd_go = ar_full && !s_axi_rvalid;
  assign next_aw_full = aw_full ? !wr_go : (s_axi_awvalid && s_axi_awready);
  assign next_w_full = w_full ? !wr_go : (s_axi_wvalid && s_axi_wready);
  assign next_ar_full = ar_full ? !rd_go : (s_axi_arvalid && s_axi_arready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      s_axi_awready <= 1'b0;
      aw_idx <= '0;
    end else begin
      aw_full <= next_aw_full;
      s_axi_awready <= !next_aw_full;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_idx <= s_axi_awaddr[ADDR_W-1:2];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      s_axi_wready <= 1'b0;
      wr_data <= '0;
      wr_lane0 <= 1'b0;
    end else begin
      w_full <= next_w_full;
      s_axi_wready <= !next_w_full;
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data <= s_axi_wdata;
        wr_lane0 <= s_axi_wstrb[0];
      end
    end
  end

  always_comb begin
    case (aw_idx)
      IDX_CTRL, IDX_CORE, IDX_FLAGS, IDX_MASK0,
      IDX_MASK1, IDX_MASK2, IDX_MASK3: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register writes; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      change_group_control <= CTRL_RESET; // R10
      global_irq_enable <= GLOBAL_EN_RESET;
      pin_mask <= {NUM_GROUPS{MASK_RESET}}; // R13
    end else if (wr_go && wr_lane0) begin
      case (aw_idx)
        IDX_CTRL: change_group_control <= wr_data[NUM_GROUPS-1:0]; // R10
        IDX_CORE: global_irq_enable <= wr_data[GLOBAL_EN_BIT];
        IDX_MASK0: pin_mask[0*GROUP_W +: GROUP_W] <=
          wr_data[GROUP_W-1:0]; // R08
        IDX_MASK1: pin_mask[1*GROUP_W +: GROUP_W] <=
          wr_data[GROUP_W-1:0]; // R07
        IDX_MASK2: pin_mask[2*GROUP_W +: GROUP_W] <=
          wr_data[GROUP_W-1:0]; // R06
        IDX_MASK3: pin_mask[3*GROUP_W +: GROUP_W] <=
          wr_data[GROUP_W-1:0]; // R05
        default: ;
      endcase
    end
  end

  // flag clears: write-one from software or vector taken by the core
  always_comb begin
    flag_clear = vector_taken; // R03
    if (wr_go && wr_lane0 && aw_idx == IDX_FLAGS) begin
      flag_clear = flag_clear | wr_data[NUM_GROUPS-1:0]; // R04
    end
  end

  // a change arriving with its clear still sets the flag
  assign next_flags = (change_group_flags & ~flag_clear) | group_hit; // R01 R11
  assign next_request = next_flags & change_group_control
    & {NUM_GROUPS{global_irq_enable}}; // R02

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      change_group_flags <= FLAGS_RESET;
    end else begin
      change_group_flags <= next_flags; // R01 R03 R04 R11
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_request <= '0;
      irq <= 1'b0;
    end else begin
      vector_request <= next_request; // R02
      irq <= |next_request;
    end
  end

  // read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_full <= 1'b0;
      s_axi_arready <= 1'b0;
      ar_idx <= '0;
    end else begin
      ar_full <= next_ar_full;
      s_axi_arready <= !next_ar_full;
      if (s_axi_arvalid && s_axi_arready) begin
        ar_idx <= s_axi_araddr[ADDR_W-1:2];
      end
    end
  end

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (ar_idx)
      IDX_CTRL: rd_word[NUM_GROUPS-1:0] = change_group_control; // R10
      IDX_CORE: rd_word[GLOBAL_EN_BIT] = global_irq_enable;
      IDX_FLAGS: rd_word[NUM_GROUPS-1:0] = change_group_flags;
      IDX_MASK0: rd_word[GROUP_W-1:0] = pin_mask[0*GROUP_W +: GROUP_W];
      IDX_MASK1: rd_word[GROUP_W-1:0] = pin_mask[1*GROUP_W +: GROUP_W];
      IDX_MASK2: rd_word[GROUP_W-1:0] = pin_mask[2*GROUP_W +: GROUP_W];
      IDX_MASK3: rd_word[GROUP_W-1:0] = pin_mask[3*GROUP_W +: GROUP_W];
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  flag0_set_a: // R01
  assert property (group_hit[0] |=> change_group_flags[0])
  else $error("group 0 change did not set its flag");

  flag_upper_a: // R11
  assert property (|group_hit[3:1] |=>
    ((change_group_flags & $past(group_hit)) == $past(group_hit)))
  else $error("upper group change did not set its flag");

  vector_req_a: // R02
  assert property (vector_request == (change_group_flags
    & $past(change_group_control)
    & {NUM_GROUPS{$past(global_irq_enable)}}))
  else $error("vector request does not follow flag and enables");

  vector_clr_a: // R03
  assert property ((vector_taken & ~group_hit) != '0 |=>
    (change_group_flags & $past(vector_taken & ~group_hit)) == '0)
  else $error("taken vector left its flag set");

  w1c_clr_a: // R04
  assert property ((flag_clear & ~group_hit) != '0 |=>
    (change_group_flags & $past(flag_clear & ~group_hit)) == '0)
  else $error("write one did not clear the flag");

  w0_keep_a: // R04
  assert property (1'b1 |=> (($past(change_group_flags)
    & ~$past(flag_clear)) & ~change_group_flags) == '0)
  else $error("flag lost without a clear");

  grp3_gate_a: // R05
  assert property (group_hit[3] |-> $past(change_group_control[3])
    && $past(pin_mask[3*GROUP_W +: GROUP_W]) != '0)
  else $error("group 3 change while disabled");

  grp2_gate_a: // R06
  assert property (group_hit[2] |-> $past(change_group_control[2])
    && $past(pin_mask[2*GROUP_W +: GROUP_W]) != '0)
  else $error("group 2 change while disabled");

  grp1_gate_a: // R07
  assert property (group_hit[1] |-> $past(change_group_control[1])
    && $past(pin_mask[1*GROUP_W +: GROUP_W]) != '0)
  else $error("group 1 change while disabled");

  grp0_gate_a: // R08
  assert property (group_hit[0] |-> $past(change_group_control[0])
    && $past(pin_mask[0*GROUP_W +: GROUP_W]) != '0)
  else $error("group 0 change while disabled");

  ctrl_read_a: // R10
  assert property (s_axi_rvalid && ar_idx == IDX_CTRL |->
    s_axi_rdata[DATA_W-1:NUM_GROUPS] == '0)
  else $error("control upper bits not zero");

  mask_reset_a: // R13
  assert property (@(posedge aclk) $rose(aresetn) |-> pin_mask == '0)
  else $error("masks not zero after reset");
endmodule
`default_nettype wire

// ===== pcirq_core_model.sv
// Purpose: model of the pins and of the core's interrupt unit
// Assumes: the core takes at most one vector every two cycles
// Notes: ack_en lets the bench leave requests pending
`timescale 1ns/100ps
`default_nettype none
module pcirq_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pcirq_pkg::NUM_PINS-1:0] pin_level,
  input wire logic ack_en,
  input wire logic [pcirq_pkg::NUM_GROUPS-1:0] vector_request,
  output logic [pcirq_pkg::NUM_PINS-1:0] change_pins,
  output logic [pcirq_pkg::NUM_GROUPS-1:0] vector_taken
);
  import pcirq_pkg::*;
  logic [NUM_GROUPS-1:0] next_taken;
  assign change_pins = pin_level;
  // lowest pending group wins; the cycle after a take is skipped
  assign next_taken = (ack_en && vector_taken == 4'h0) ?
    (vector_request & (~vector_request + 4'h1)) : 4'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_taken <= 4'h0;
    end else begin
      vector_taken <= next_taken;
    end
  end
endmodule
`default_nettype wire

// ===== testbench.sv
// Purpose: self-checking bench for the pin-change interrupt block
// Assumes: one register access at a time on the bus
// Notes: pins and vector acceptance pass through the core model
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pcirq_pkg::*;
  logic aclk, aresetn, ack_en;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, irq;
  logic [NUM_PINS-1:0] pins, change_pins;
  logic [NUM_GROUPS-1:0] vector_taken, vector_request;
  logic [IDX_W-1:0] midx [4];
  int mismatches, compares, g, taken;
  pcirq_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .change_pins, .vector_taken, .vector_request, .irq);
  pcirq_core_model u_core (.aclk, .aresetn, .pin_level(pins), .ack_en,
    .vector_request, .change_pins, .vector_taken);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (vector_taken != 4'h0) taken++;
  end
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_up(input int n);
    if (n >= 50) begin
      mismatches++;
      complete_run;
    end
  endtask
  task automatic wr(input logic [IDX_W-1:0] i, input logic [31:0] d,
      input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    give_up(n);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask
  task automatic rd(input logic [IDX_W-1:0] i, input logic [31:0] d,
      input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    give_up(n);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, d);
    chk("rresp", s_axi_rresp, er);
  endtask
  // flip one pin, then give the synchroniser and flag time to settle
  task automatic tog(input int b);
    @(posedge aclk);
    pins[b] <= ~pins[b];
    repeat (6) @(posedge aclk);
  endtask
  initial begin
    aresetn = 1'b0;
    ack_en = 1'b0;
    pins = 32'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awprot, s_axi_arprot} = 6'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_wstrb = 4'hf;
    midx = '{IDX_MASK0, IDX_MASK1, IDX_MASK2, IDX_MASK3};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (g = 0; g < 4; g++) rd(midx[g], 32'h0, RESP_OKAY);
    rd(IDX_CTRL, 32'h0, RESP_OKAY);
    rd(IDX_FLAGS, 32'h0, RESP_OKAY);
    rd(10'h3ff, 32'h0, RESP_SLVERR);
    wr(10'h3ff, 32'hffffffff, RESP_SLVERR);
    wr(IDX_CTRL, 32'hffffffff, RESP_OKAY);
    rd(IDX_CTRL, 32'hf, RESP_OKAY);
    s_axi_wstrb <= 4'he;
    wr(IDX_CTRL, 32'h0, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(IDX_CTRL, 32'hf, RESP_OKAY);
    wr(IDX_CORE, 32'h1, RESP_OKAY);
    for (g = 0; g < 4; g++) begin
      wr(midx[g], 32'h80, RESP_OKAY);
      rd(midx[g], 32'h80, RESP_OKAY);
      tog(8 * g);
      rd(IDX_FLAGS, 32'h0, RESP_OKAY);
      tog(8 * g + 7);
      rd(IDX_FLAGS, 32'h1 << g, RESP_OKAY);
      chk("vector_request", vector_request, 32'h1 << g);
      chk("irq", irq, 32'h1);
      wr(IDX_FLAGS, 32'h0, RESP_OKAY);
      rd(IDX_FLAGS, 32'h1 << g, RESP_OKAY);
      wr(IDX_FLAGS, 32'h1 << g, RESP_OKAY);
      repeat (6) @(posedge aclk);
      rd(IDX_FLAGS, 32'h0, RESP_OKAY);
      chk("irq", irq, 32'h0);
      ack_en <= 1'b1;
      tog(8 * g + 7);
      rd(IDX_FLAGS, 32'h0, RESP_OKAY);
      chk("taken", taken, g + 1);
      ack_en <= 1'b0;
      wr(midx[g], 32'h0, RESP_OKAY);
    end
    // group enable off: an enabled pin must not raise the flag
    wr(IDX_CTRL, 32'h0, RESP_OKAY);
    wr(midx[0], 32'hff, RESP_OKAY);
    tog(3);
    rd(IDX_FLAGS, 32'h0, RESP_OKAY);
    // global enable off: flag sets but no vector is requested
    wr(IDX_CTRL, 32'h1, RESP_OKAY);
    wr(IDX_CORE, 32'h0, RESP_OKAY);
    tog(3);
    rd(IDX_FLAGS, 32'h1, RESP_OKAY);
    chk("vector_request", vector_request, 32'h0);
    chk("irq", irq, 32'h0);
    // reset in mid-run: written mask, enable and flag return to zero
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(midx[0], 32'h0, RESP_OKAY);
    rd(IDX_CTRL, 32'h0, RESP_OKAY);
    rd(IDX_FLAGS, 32'h0, RESP_OKAY);
    chk("irq", irq, 32'h0);
    complete_run;
  end
endmodule
`default_nettype wire
